// *** shared/svdg_pkg.sv ***
package svdg_pkg;

  // ***************************************************
  // fixed point and modulation constants
  // ***************************************************
  localparam int FRAC_BITS = 12;
  localparam logic signed [15:0] VDC_PU = 16'sh1B8D;
  localparam logic signed [15:0] BUS_SCALE = 16'sh0245;
  localparam logic signed [16:0] PERIOD_COUNT = 17'sh003E8;
  localparam logic signed [15:0] SQRT3 = 16'sh1BB7;
  localparam logic signed [15:0] SQRT3_HALF = 16'sh0DDB;
  localparam logic signed [15:0] THREE_HALF = 16'sh1800;

  // ***************************************************
  // timing
  // ***************************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int TICK_NS = 50;
  localparam int CTRL_PERIOD_NS = 2 * 1000 * TICK_NS;
  localparam int CTRL_PERIOD_CYCLES = CTRL_PERIOD_NS / CLK_PERIOD_NS;
  localparam int DIV_STEPS = 32;

  // ***************************************************
  // register port map
  // ***************************************************
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h1;
  localparam logic [3:0] REG_CMP_U = 4'h2;
  localparam logic [3:0] REG_CMP_V = 4'h3;
  localparam logic [3:0] REG_CMP_W = 4'h4;
  localparam logic [3:0] REG_VDC = 4'h5;
  localparam int CTRL_ENABLE_BIT = 0;
  localparam logic CTRL_RESET = 1'b0;
  localparam int STAT_SECTOR_LSB = 0;
  localparam int STAT_BUSY_BIT = 4;
  localparam int STAT_SAT_BIT = 5;
  localparam int STAT_PEND_BIT = 6;

  // ***************************************************
  // sequencer states
  // ***************************************************
  typedef enum logic [6:0] {
    ST_IDLE = 7'b0000001,
    ST_MUL  = 7'b0000010,
    ST_XYZ  = 7'b0000100,
    ST_SECT = 7'b0001000,
    ST_DIV  = 7'b0010000,
    ST_ONT  = 7'b0100000,
    ST_DONE = 7'b1000000
  } svdg_state_e;

endpackage

// *** hw/svdg_space_vector_duty_generator.sv ***
// Chosen here: the address map and the address-and-strobe port.
`timescale 1ns/1ps

// Operation
// R1 - alpha and beta references come in, the bus value is a parameter, three phase compare values go out.
// R2 - every voltage input and the bus value are signed 4.12 fixed point.
// R3 - the per-unit bus value defaults to 1.722, coded 1B8D hex.
// R4 - the scaling constant is period count over bus value, 581 or 245 hex for a period of 1000.
// R5 - three auxiliary values and the X, Y, Z products are formed from the references.
// R6 - sector is one for a positive first aux value plus two for the second plus four for the third.
// R7 - the two active durations are picked from X, Y, Z and their negatives by sector.
// R8 - when both durations sum past the period count they are rescaled so they total the period count.
// R9 - on-times are a = (period - t1 - t2)/2, b = a + t1, c = b + t2.
// R10 - on-times are routed to the three compare channels by the sector table.
// R11 - the computation runs once per control period on the first timer underflow.
// R12 - the period count is 1000 ticks of 50 ns, a 100 us control period.
// R13 - all three compare values change together at one carrier boundary.
// R14 - products truncate to 12 fraction bits and sectors 0 and 7 give zero durations.
module svdg_space_vector_duty_generator #(
  parameter logic signed [15:0] VDC_PU = svdg_pkg::VDC_PU,
  parameter logic signed [15:0] BUS_SCALE = svdg_pkg::BUS_SCALE,
  parameter logic signed [16:0] PERIOD_COUNT = svdg_pkg::PERIOD_COUNT // R12
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic signed [15:0] alpha_ref_i,
  input wire logic signed [15:0] beta_ref_i,
  input wire logic first_gp_timer_underflow_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [15:0] reg_rdata_o,
  output logic [15:0] phase_u_compare_o,
  output logic [15:0] phase_v_compare_o,
  output logic [15:0] phase_w_compare_o,
  output logic compare_load_o,
  output logic [2:0] sector_o
);

  // ***************************************************
  // state
  // ***************************************************
  svdg_pkg::svdg_state_e state_q;
  logic enable_q;
  logic signed [15:0] alpha_q, beta_q;
  logic signed [15:0] ka_q, kb_q, aux_two_q, aux_three_q;
  logic signed [15:0] x_q, y_q, z_q;
  logic [2:0] sector_q;
  logic signed [15:0] first_active_duration_q, second_active_duration_q;
  logic [31:0] div_num_q;
  logic [17:0] div_rem_q;
  logic [5:0] div_cnt_q;
  logic sat_q;
  logic [15:0] pend_u_q, pend_v_q, pend_w_q;
  logic pend_valid_q;

  // ***************************************************
  // combinational arithmetic
  // ***************************************************
  logic signed [31:0] prod_ka, prod_kb, prod_r3a;
  logic signed [31:0] prod_x, prod_y1, prod_y2;
  logic signed [15:0] r3a, aux_one, v2_pre, v3_pre;
  logic signed [16:0] dur_sum;
  logic [17:0] div_try;
  logic [16:0] div_den;
  logic signed [16:0] ton_a, ton_b, ton_c;
  logic signed [15:0] sel_t1, sel_t2;
  logic signed [16:0] sel_sum;

  // scaled references: bus constant times alpha and beta, back to counts
  assign prod_ka = BUS_SCALE * alpha_q; // R4
  assign prod_kb = BUS_SCALE * beta_q; // R4
  assign prod_r3a = svdg_pkg::SQRT3 * alpha_q;
  assign r3a = prod_r3a[27:12]; // R14
  assign aux_one = beta_q; // R5
  assign v2_pre = r3a - beta_q;
  assign v3_pre = -r3a - beta_q;

  // products for X, Y and Z from the already scaled references
  assign prod_x = svdg_pkg::SQRT3 * kb_q; // R5
  assign prod_y1 = svdg_pkg::SQRT3_HALF * kb_q; // R5
  assign prod_y2 = svdg_pkg::THREE_HALF * ka_q; // R5

  assign dur_sum = 17'(first_active_duration_q)
                 + 17'(second_active_duration_q);
  assign div_den = 17'(dur_sum);
  assign div_try = {div_rem_q[16:0], div_num_q[31]};

  // on-times, computed after any rescaling has finished
  assign ton_a = (PERIOD_COUNT - 17'(first_active_duration_q)
               - 17'(second_active_duration_q)) >>> 1; // R9
  assign ton_b = ton_a + 17'(first_active_duration_q); // R9
  assign ton_c = ton_b + 17'(second_active_duration_q); // R9

  // durations picked straight from X, Y, Z so the saturation test sees this pass
  always_comb begin
    case (sector_q) // R7
      3'h1: {sel_t1, sel_t2} = {z_q, y_q};
      3'h2: {sel_t1, sel_t2} = {y_q, -x_q};
      3'h3: {sel_t1, sel_t2} = {-z_q, x_q};
      3'h4: {sel_t1, sel_t2} = {-x_q, z_q};
      3'h5: {sel_t1, sel_t2} = {x_q, -y_q};
      3'h6: {sel_t1, sel_t2} = {-y_q, -z_q};
      default: {sel_t1, sel_t2} = {16'sh0000, 16'sh0000}; // R14
    endcase
  end
  assign sel_sum = 17'(sel_t1) + 17'(sel_t2); // R8

  // ***************************************************
  // register port
  // ***************************************************
  // control register: only the enable bit is stored
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      enable_q <= svdg_pkg::CTRL_RESET;
    end else if (reg_wr_i && reg_addr_i == svdg_pkg::REG_CTRL) begin
      enable_q <= reg_wdata_i[svdg_pkg::CTRL_ENABLE_BIT];
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      reg_rdata_o <= 16'h0000;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        svdg_pkg::REG_CTRL: begin
          reg_rdata_o <= {15'h0000, enable_q};
        end
        svdg_pkg::REG_STATUS: begin
          reg_rdata_o <= {9'h000, pend_valid_q, sat_q,
                          (state_q != svdg_pkg::ST_IDLE), 1'b0,
                          sector_q};
        end
        svdg_pkg::REG_CMP_U: reg_rdata_o <= phase_u_compare_o;
        svdg_pkg::REG_CMP_V: reg_rdata_o <= phase_v_compare_o;
        svdg_pkg::REG_CMP_W: reg_rdata_o <= phase_w_compare_o;
        svdg_pkg::REG_VDC: reg_rdata_o <= VDC_PU; // R3
        default: reg_rdata_o <= 16'h0000;
      endcase
    end else begin
      reg_rdata_o <= 16'h0000;
    end
  end

  // ***************************************************
  // sequencer
  // ***************************************************
  // one pass per underflow; an underflow while busy is dropped so a
  // half-computed set never mixes with fresh samples
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q <= svdg_pkg::ST_IDLE;
    end else begin
      case (state_q)
        svdg_pkg::ST_IDLE: begin
          if (first_gp_timer_underflow_i && enable_q) begin
            state_q <= svdg_pkg::ST_MUL; // R11
          end
        end
        svdg_pkg::ST_MUL: state_q <= svdg_pkg::ST_XYZ;
        svdg_pkg::ST_XYZ: state_q <= svdg_pkg::ST_SECT;
        svdg_pkg::ST_SECT: begin
          if (sel_sum > PERIOD_COUNT) begin
            state_q <= svdg_pkg::ST_DIV; // R8
          end else begin
            state_q <= svdg_pkg::ST_ONT;
          end
        end
        svdg_pkg::ST_DIV: begin
          if (div_cnt_q == 6'(svdg_pkg::DIV_STEPS)) begin
            state_q <= svdg_pkg::ST_ONT;
          end
        end
        svdg_pkg::ST_ONT: state_q <= svdg_pkg::ST_DONE;
        svdg_pkg::ST_DONE: state_q <= svdg_pkg::ST_IDLE;
        default: state_q <= svdg_pkg::ST_IDLE;
      endcase
    end
  end

  // ***************************************************
  // sampling and products
  // ***************************************************
  // references are frozen at the underflow for the whole pass
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      alpha_q <= 16'sh0000;
      beta_q <= 16'sh0000;
    end else if (state_q == svdg_pkg::ST_IDLE
                 && first_gp_timer_underflow_i && enable_q) begin
      alpha_q <= alpha_ref_i; // R1 R2
      beta_q <= beta_ref_i; // R1 R2
    end
  end

  // scaled references and the halved aux values
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ka_q <= 16'sh0000;
      kb_q <= 16'sh0000;
      aux_two_q <= 16'sh0000;
      aux_three_q <= 16'sh0000;
    end else if (state_q == svdg_pkg::ST_MUL) begin
      ka_q <= prod_ka[27:12]; // R14
      kb_q <= prod_kb[27:12]; // R14
      aux_two_q <= v2_pre >>> 1; // R5
      aux_three_q <= v3_pre >>> 1; // R5
    end
  end

  // X, Y, Z and the sector flags
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      x_q <= 16'sh0000;
      y_q <= 16'sh0000;
      z_q <= 16'sh0000;
      sector_q <= 3'h0;
    end else if (state_q == svdg_pkg::ST_XYZ) begin
      x_q <= prod_x[27:12]; // R5 R14
      y_q <= 16'(prod_y1[27:12] + prod_y2[27:12]); // R5 R14
      z_q <= 16'(prod_y1[27:12] - prod_y2[27:12]); // R5 R14
      sector_q <= {aux_three_q > 16'sh0000,
                   aux_two_q > 16'sh0000,
                   aux_one > 16'sh0000}; // R6
    end
  end

  // ***************************************************
  // durations and saturation
  // ***************************************************
  // the divider yields t1 scaled; t2 takes the remainder of the period
  // so the pair totals exactly the period count despite truncation
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      first_active_duration_q <= 16'sh0000;
      second_active_duration_q <= 16'sh0000;
    end else if (state_q == svdg_pkg::ST_SECT) begin
      first_active_duration_q <= sel_t1; // R7
      second_active_duration_q <= sel_t2; // R7
    end else if (state_q == svdg_pkg::ST_DIV
                 && div_cnt_q == 6'(svdg_pkg::DIV_STEPS)) begin
      first_active_duration_q <= div_num_q[15:0]; // R8
      second_active_duration_q <= 16'(PERIOD_COUNT) - div_num_q[15:0]; // R8
    end
  end

  // restoring divider: t1 * period / (t1 + t2), one bit per cycle;
  // a negative t1 is not expected in a valid sector and is not guarded
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      div_num_q <= 32'h00000000;
      div_rem_q <= 18'h00000;
      div_cnt_q <= 6'h00;
    end else if (state_q == svdg_pkg::ST_SECT) begin
      div_num_q <= 32'(sel_t1) * 32'(PERIOD_COUNT);
      div_rem_q <= 18'h00000;
      div_cnt_q <= 6'h00;
    end else if (state_q == svdg_pkg::ST_DIV
                 && div_cnt_q != 6'(svdg_pkg::DIV_STEPS)) begin
      if (div_try >= {1'b0, div_den}) begin
        div_rem_q <= div_try - {1'b0, div_den};
        div_num_q <= {div_num_q[30:0], 1'b1};
      end else begin
        div_rem_q <= div_try;
        div_num_q <= {div_num_q[30:0], 1'b0};
      end
      div_cnt_q <= div_cnt_q + 6'h01;
    end
  end

  // saturation flag for software, refreshed every pass
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sat_q <= 1'b0;
    end else if (state_q == svdg_pkg::ST_SECT) begin
      sat_q <= (sel_sum > PERIOD_COUNT); // R8
    end
  end

  // ***************************************************
  // phase routing
  // ***************************************************
  // results wait in a pending set until the next carrier boundary
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_u_q <= 16'h0000;
      pend_v_q <= 16'h0000;
      pend_w_q <= 16'h0000;
    end else if (state_q == svdg_pkg::ST_ONT) begin
      case (sector_q) // R10
        3'h1: begin
          pend_u_q <= ton_b[15:0];
          pend_v_q <= ton_a[15:0];
          pend_w_q <= ton_c[15:0];
        end
        3'h2: begin
          pend_u_q <= ton_a[15:0];
          pend_v_q <= ton_c[15:0];
          pend_w_q <= ton_b[15:0];
        end
        3'h3: begin
          pend_u_q <= ton_a[15:0];
          pend_v_q <= ton_b[15:0];
          pend_w_q <= ton_c[15:0];
        end
        3'h4: begin
          pend_u_q <= ton_c[15:0];
          pend_v_q <= ton_b[15:0];
          pend_w_q <= ton_a[15:0];
        end
        3'h5: begin
          pend_u_q <= ton_c[15:0];
          pend_v_q <= ton_a[15:0];
          pend_w_q <= ton_b[15:0];
        end
        3'h6: begin
          pend_u_q <= ton_b[15:0];
          pend_v_q <= ton_c[15:0];
          pend_w_q <= ton_a[15:0];
        end
        default: begin
          pend_u_q <= ton_a[15:0];
          pend_v_q <= ton_a[15:0];
          pend_w_q <= ton_a[15:0];
        end
      endcase
    end
  end

  // pending flag: the done state sets it, the boundary load clears it;
  // if both come in one cycle the done state wins, as the clear is not limited to idle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pend_valid_q <= 1'b0;
    end else if (state_q == svdg_pkg::ST_DONE) begin
      pend_valid_q <= 1'b1;
    end else if (first_gp_timer_underflow_i) begin
      pend_valid_q <= 1'b0;
    end
  end

  // ***************************************************
  // compare outputs
  // ***************************************************
  // all three channels load on the same underflow edge
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      phase_u_compare_o <= 16'h0000;
      phase_v_compare_o <= 16'h0000;
      phase_w_compare_o <= 16'h0000;
      sector_o <= 3'h0;
      compare_load_o <= 1'b0;
    end else if (first_gp_timer_underflow_i && pend_valid_q) begin
      phase_u_compare_o <= pend_u_q; // R13
      phase_v_compare_o <= pend_v_q; // R13
      phase_w_compare_o <= pend_w_q; // R13
      sector_o <= sector_q;
      compare_load_o <= 1'b1; // R13
    end else begin
      compare_load_o <= 1'b0;
    end
  end

endmodule

// *** test/svdg_sva.sv ***
`timescale 1ns/1ps
// ********************
// port checker
// ********************
module svdg_sva #(
  parameter logic signed [16:0] PERIOD_COUNT = 17'sh003E8
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic first_gp_timer_underflow_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_rdata_o,
  input wire logic [15:0] phase_u_compare_o,
  input wire logic [15:0] phase_v_compare_o,
  input wire logic [15:0] phase_w_compare_o,
  input wire logic compare_load_o,
  input wire logic [2:0] sector_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // centre of the carrier, the idle duty
  logic [15:0] half_c;
  assign half_c = PERIOD_COUNT[16:1];
  sequence s_load;
    compare_load_o;
  endsequence
  sequence s_uf_recent;
    $past(first_gp_timer_underflow_i) || $past(first_gp_timer_underflow_i, 2);
  endsequence
  sequence s_any_change;
    $changed(phase_u_compare_o) || $changed(phase_v_compare_o) ||
    $changed(phase_w_compare_o) || $changed(sector_o);
  endsequence
  property p_load_once;
    s_load |=> (!compare_load_o)[*2];
  endproperty
  property p_load_cause;
    s_load |-> $past(first_gp_timer_underflow_i);
  endproperty
  property p_change_cause;
    s_any_change |-> s_uf_recent;
  endproperty
  property p_change_load;
    s_any_change |-> ##[0:1] compare_load_o;
  endproperty
  // values are judged a cycle after the strobe, when all have landed
  property p_idle_mid;
    s_load ##1 (sector_o == 3'd0 || sector_o == 3'd7) |->
      phase_u_compare_o == half_c && phase_v_compare_o == half_c &&
      phase_w_compare_o == half_c;
  endproperty
  property p_sect3;
    s_load ##1 sector_o == 3'd3 |->
      phase_u_compare_o <= phase_v_compare_o &&
      phase_v_compare_o <= phase_w_compare_o;
  endproperty
  property p_sect4;
    s_load ##1 sector_o == 3'd4 |->
      phase_u_compare_o >= phase_v_compare_o &&
      phase_v_compare_o >= phase_w_compare_o;
  endproperty
  property p_bus_read;
    reg_rd_i && reg_addr_i == 4'h5 |=> reg_rdata_o == 16'h1B8D;
  endproperty
  property p_rdata_idle;
    !reg_rd_i |=> reg_rdata_o == 16'h0000;
  endproperty
  a_load_once: assert property (p_load_once)
    else $error("load strobe longer than one cycle");
  a_load_cause: assert property (p_load_cause)
    else $error("load strobe without underflow");
  a_change_cause: assert property (p_change_cause)
    else $error("compare set changed away from underflow");
  a_change_load: assert property (p_change_load)
    else $error("compare set changed without load strobe");
  a_idle_mid: assert property (p_idle_mid)
    else $error("null sector not at carrier centre");
  a_sect3: assert property (p_sect3)
    else $error("sector three channel order wrong");
  a_sect4: assert property (p_sect4)
    else $error("sector four channel order wrong");
  a_bus_read: assert property (p_bus_read)
    else $error("bus value readback wrong");
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data not zero outside read");
endmodule

bind svdg_space_vector_duty_generator svdg_sva #(
  .PERIOD_COUNT(PERIOD_COUNT)
) u_sva (
  .sys_clk_i(sys_clk_i),
  .reset_n_i(reset_n_i),
  .first_gp_timer_underflow_i(first_gp_timer_underflow_i),
  .reg_addr_i(reg_addr_i),
  .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o),
  .phase_u_compare_o(phase_u_compare_o),
  .phase_v_compare_o(phase_v_compare_o),
  .phase_w_compare_o(phase_w_compare_o),
  .compare_load_o(compare_load_o),
  .sector_o(sector_o)
);

// *** test/svdg_pwm_unit_model.sv ***
`timescale 1ns/1ps
// ********************
// carrier compare unit
// ********************
module svdg_pwm_unit_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [15:0] cmp_u_i,
  input wire logic [15:0] cmp_v_i,
  input wire logic [15:0] cmp_w_i,
  input wire logic load_i,
  output logic [15:0] shadow_u_o,
  output logic [15:0] shadow_v_o,
  output logic [15:0] shadow_w_o,
  output logic [7:0] load_count_o
);
  logic load_q;
  // takes the set a cycle late so either edge reading is safe
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      load_q <= 1'b0;
      shadow_u_o <= 16'h0000;
      shadow_v_o <= 16'h0000;
      shadow_w_o <= 16'h0000;
      load_count_o <= 8'h00;
    end else begin
      load_q <= load_i;
      if (load_q) begin
        shadow_u_o <= cmp_u_i;
        shadow_v_o <= cmp_v_i;
        shadow_w_o <= cmp_w_i;
        load_count_o <= load_count_o + 8'h01;
      end
    end
  end
endmodule

// *** test/tb_space_vector_duty_generator.sv ***
`timescale 1ns/1ps
module tb_space_vector_duty_generator;
  localparam int PC = 1000;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic signed [15:0] alpha = 16'sh0000;
  logic signed [15:0] beta = 16'sh0000;
  logic uf = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [15:0] rdata, cu, cv, cw, mu, mv, mw;
  logic load;
  logic [2:0] sector;
  logic [7:0] lcnt;
  int errors = 0;
  int samples_checked = 0;
  logic signed [15:0] tab_a [8] = '{16'h0000, 16'h0376, 16'h0000,
    16'hFC8A, 16'hFC8A, 16'h0000, 16'h0376, 16'h0000};
  logic signed [15:0] tab_b [8] = '{16'h0000, 16'h0200, 16'h0400,
    16'h0200, 16'hFE00, 16'hFC00, 16'hFE00, 16'h1800};
  always #4 clk = ~clk;
  // ********************
  // design and far side
  // ********************
  svdg_space_vector_duty_generator #(
    .PERIOD_COUNT(17'(PC))
  ) dut (
    .sys_clk_i(clk),
    .reset_n_i(reset_n),
    .alpha_ref_i(alpha),
    .beta_ref_i(beta),
    .first_gp_timer_underflow_i(uf),
    .reg_addr_i(addr),
    .reg_wdata_i(wdata),
    .reg_wr_i(wr),
    .reg_rd_i(rd),
    .reg_rdata_o(rdata),
    .phase_u_compare_o(cu),
    .phase_v_compare_o(cv),
    .phase_w_compare_o(cw),
    .compare_load_o(load),
    .sector_o(sector)
  );
  svdg_pwm_unit_model pwm (
    .clk_i(clk),
    .reset_n_i(reset_n),
    .cmp_u_i(cu),
    .cmp_v_i(cv),
    .cmp_w_i(cw),
    .load_i(load),
    .shadow_u_o(mu),
    .shadow_v_o(mv),
    .shadow_w_o(mw),
    .load_count_o(lcnt)
  );
  // ********************
  // helpers
  // ********************
  task chk(input string name, input logic [15:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data is taken in the one cycle it stands
  task rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task pulse_uf;
    @(posedge clk);
    uf <= 1'b1;
    @(posedge clk);
    uf <= 1'b0;
  endtask
  // keeps bits 27..12 of a product, as the fixed point does
  function automatic int q12(input int p);
    logic signed [15:0] s;
    s = p[27:12];
    return s;
  endfunction
  task automatic expect_set(input int al, be, output logic [15:0] eu, ev,
    ew, output logic [2:0] es, output logic sat);
    int ka, kb, x, y, z, t1, t2, a, b, c, sa;
    ka = q12('h245 * al);
    kb = q12('h245 * be);
    x = q12('h1BB7 * kb);
    y = q12('h0DDB * kb) + q12('h1800 * ka);
    z = q12('h0DDB * kb) - q12('h1800 * ka);
    sa = q12('h1BB7 * al);
    es = 3'((be > 0) + 2 * (((sa - be) >>> 1) > 0) +
      4 * (((-sa - be) >>> 1) > 0));
    t1 = 0;
    t2 = 0;
    case (es)
      3'd1: begin t1 = z; t2 = y; end
      3'd2: begin t1 = y; t2 = -x; end
      3'd3: begin t1 = -z; t2 = x; end
      3'd4: begin t1 = -x; t2 = z; end
      3'd5: begin t1 = x; t2 = -y; end
      3'd6: begin t1 = -y; t2 = -z; end
      default: t1 = 0;
    endcase
    sat = (t1 + t2 > PC);
    if (sat) begin
      t1 = t1 * PC / (t1 + t2);
      t2 = PC - t1;
    end
    a = (PC - t1 - t2) >>> 1;
    b = a + t1;
    c = b + t2;
    case (es)
      3'd1: {eu, ev, ew} = {16'(b), 16'(a), 16'(c)};
      3'd2: {eu, ev, ew} = {16'(a), 16'(c), 16'(b)};
      3'd3: {eu, ev, ew} = {16'(a), 16'(b), 16'(c)};
      3'd4: {eu, ev, ew} = {16'(c), 16'(b), 16'(a)};
      3'd5: {eu, ev, ew} = {16'(c), 16'(a), 16'(b)};
      3'd6: {eu, ev, ew} = {16'(b), 16'(c), 16'(a)};
      default: {eu, ev, ew} = {16'(a), 16'(a), 16'(a)};
    endcase
  endtask
  // ********************
  // scenarios
  // ********************
  task t_reset;
    logic [15:0] d;
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    #1 chk("cmp_u_rst", cu, 16'h0000);
    rd_reg(4'h0, d);
    chk("ctrl", d, 16'h0000);
    rd_reg(4'h5, d);
    chk("bus_pu", d, 16'h1B8D);
    rd_reg(4'hF, d);
    chk("unmapped", d, 16'h0000);
    wr_reg(4'h5, 16'h0000);
    rd_reg(4'h5, d);
    chk("bus_ro", d, 16'h1B8D);
  endtask
  // underflows while disabled must not start or load anything
  task t_disabled;
    logic [7:0] n0;
    n0 = lcnt;
    pulse_uf;
    repeat (40) @(posedge clk);
    pulse_uf;
    repeat (4) @(posedge clk);
    chk("idle_loads", 16'(lcnt - n0), 16'h0000);
  endtask
  // first underflow starts a pass, the next one presents it
  task automatic run_case(input logic signed [15:0] al, be);
    logic [15:0] eu, ev, ew, st;
    logic [2:0] es;
    logic sat;
    logic [7:0] n0;
    expect_set(al, be, eu, ev, ew, es, sat);
    @(posedge clk);
    alpha <= al;
    beta <= be;
    pulse_uf;
    repeat (60) @(posedge clk);
    n0 = lcnt;
    pulse_uf;
    repeat (4) @(posedge clk);
    #1 chk("loads", 16'(lcnt - n0), 16'h0001);
    chk("cmp_u", mu, eu);
    chk("cmp_v", mv, ev);
    chk("cmp_w", mw, ew);
    chk("sector", 16'(sector), 16'(es));
    repeat (60) @(posedge clk);
    rd_reg(4'h1, st);
    chk("status", st & 16'h0027, {10'h000, sat, 2'b00, es});
    rd_reg(4'h2, st);
    chk("cmp_u_reg", st, eu);
  endtask
  initial begin
    logic [15:0] d;
    t_reset;
    t_disabled;
    wr_reg(4'h0, 16'h0001);
    rd_reg(4'h0, d);
    chk("ctrl_en", d, 16'h0001);
    for (int i = 0; i < 8; i++) begin
      run_case(tab_a[i], tab_b[i]);
    end
    t_reset;
    test_done;
  end
  // cuts a hang well past the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    test_done;
  end
endmodule
